// file: rtl/adf_cfg.svh
// Purpose: Constants for the dual ancillary-data FIFO block
// Assumes: Included by bare name; definitions only
// Notes: Offsets are byte addresses on the register bus
`ifndef ADF_CFG_SVH
`define ADF_CFG_SVH
// ----------------------------------------
// FIFO geometry and thresholds
// ----------------------------------------
`define ADF_DEPTH 1024
`define ADF_WORD_W 10
`define ADF_ALMOST_EMPTY 32
`define ADF_HALF_FULL 512
`define ADF_ALMOST_FULL 992
`define ADF_STATUS_STAGES 3
// ----------------------------------------
// Video blanking levels
// ----------------------------------------
`define ADF_LUMA_BLANK 10'h040
`define ADF_CHROMA_BLANK 10'h200
// ----------------------------------------
// Register map and reset values
// ----------------------------------------
`define ADF_AXI_ADDR_W 8
`define ADF_OFF_IRQ_STATUS 8'h00
`define ADF_OFF_IRQ_CLEAR 8'h04
`define ADF_OFF_IRQ_ENABLE 8'h08
`define ADF_OFF_FILL 8'h0C
`define ADF_IRQ_W 4
`define ADF_IRQ_ENABLE_RST 4'h0
`define ADF_RESP_OKAY 2'b00
`define ADF_RESP_SLVERR 2'b10
`endif

// file: rtl/adf_dual_fifo_status.sv
// Purpose: Luma and chroma ancillary FIFOs with fill-level status and insertion
// Assumes: Core clock is the pixel clock; write clock is sampled as a slow pin
// Notes: Status and interrupt registers on AXI4-Lite
//
// Summary of operation
// - Video words are captured and launched on the rising pixel clock edge.
// - Blanking forces luma and chroma to blank levels together.
// - Separate 1024-word ancillary FIFOs for luma and chroma.
// - Packet contents are never checked; only occupancy is tracked.
// - A completely filled selected FIFO reports code 110.
// - Writing a full FIFO enters overrun and reports code 111.
// - A FIFO emptied by reads reports code 001.
// - Reading an empty FIFO reports 000 and inserts nothing.
// - Select high reports the luma FIFO, low the chroma FIFO.
// - Write-side codes change three write-clock cycles after the write.
// - Read-side codes change three pixel-clock cycles after the read.
// - Codes 010 almost empty, 011 ready, 100 half, 101 almost full.
// - Status flags enabled while enable input low, disabled while high.
// - Write enable low stores the input word and advances the write pointer.
// - Read enable low advances read pointer each clock and inserts the word.
`timescale 1ns/1ps
`include "adf_cfg.svh"
module adf_dual_fifo_status #(
  parameter int DEPTH = `ADF_DEPTH,
  parameter int DW = `ADF_WORD_W,
  parameter int AXI_AW = `ADF_AXI_ADDR_W
) (
  input wire logic i_core_clk, // Pixel clock
  input wire logic i_arst_n, // Async reset, active low
  input wire logic [DW-1:0] i_luma_in, // Luma video word
  input wire logic [DW-1:0] i_chroma_in, // Chroma video word
  input wire logic i_blank_req, // Force both channels to blank
  output logic [DW-1:0] o_luma_out, // Luma video word out
  output logic [DW-1:0] o_chroma_out, // Chroma video word out
  input wire logic i_wr_clk, // Writer clock pin
  input wire logic i_wr_en_n, // Write enable, active low
  input wire logic [DW-1:0] i_anc_word_in, // Ancillary word to store
  input wire logic i_luma_chroma_select, // High luma, low chroma
  input wire logic i_read_en_n, // Read enable, active low
  input wire logic i_fifo_pointer_reset_n, // Pointer reset, active low
  input wire logic i_status_flags_enable_n, // Status enable, active low
  output logic [2:0] o_fifo_level_code, // Fill-level status code
  output logic o_fifo_level_code_oe, // Status pins driven
  output logic o_irq, // Level interrupt
  input wire logic [AXI_AW-1:0] i_awaddr, // AXI write address
  input wire logic i_awvalid, // AXI write address valid
  output logic o_awready, // AXI write address ready
  input wire logic [31:0] i_wdata, // AXI write data
  input wire logic [3:0] i_wstrb, // AXI write strobes
  input wire logic i_wvalid, // AXI write data valid
  output logic o_wready, // AXI write data ready
  output logic [1:0] o_bresp, // AXI write response
  output logic o_bvalid, // AXI write response valid
  input wire logic i_bready, // AXI write response ready
  input wire logic [AXI_AW-1:0] i_araddr, // AXI read address
  input wire logic i_arvalid, // AXI read address valid
  output logic o_arready, // AXI read address ready
  output logic [31:0] o_rdata, // AXI read data
  output logic [1:0] o_rresp, // AXI read response
  output logic o_rvalid, // AXI read data valid
  input wire logic i_rready // AXI read data ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam int SW = DW + 4;
  localparam int NS = `ADF_STATUS_STAGES;
  localparam int IW = `ADF_IRQ_W;

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = '0;
    for (int k = PW - 1; k >= 0; k--) begin
      b[k] = g[k] ^ ((k == PW - 1) ? 1'b0 : b[k + 1]);
    end
    return b;
  endfunction

  // ----------------------------------------
  // Pin synchronisers for the writer side
  // ----------------------------------------
  logic [SW-1:0] pin_s1_q;
  logic [SW-1:0] pin_s2_q;
  logic wclk_last_q;
  logic wr_clk_s, wr_en_n_s, sel_s, stat_en_n_s, wr_edge;
  logic [DW-1:0] word_s;

  // Writer pins are slow, so bus and clock settle together before the edge is seen
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      wclk_last_q <= 1'b0;
    end else begin
      pin_s1_q <= {i_wr_clk, i_wr_en_n, i_luma_chroma_select, i_status_flags_enable_n,
                   i_anc_word_in};
      pin_s2_q <= pin_s1_q;
      wclk_last_q <= wr_clk_s;
    end
  end
  assign {wr_clk_s, wr_en_n_s, sel_s, stat_en_n_s, word_s} = pin_s2_q;
  assign wr_edge = wr_clk_s & ~wclk_last_q;

  // ----------------------------------------
  // Two FIFOs: index 1 luma, index 0 chroma
  // ----------------------------------------
  logic [2:0] fifo_code [2];
  logic [DW-1:0] rd_word [2];
  logic [1:0] ins_w;
  logic [1:0] ovr_evt;
  logic [1:0] und_evt;
  logic [PW-1:0] fill_cnt [2];

  for (genvar ch = 0; ch < 2; ch++) begin : g_fifo
    logic [DW-1:0] mem [DEPTH];
    logic [PW-1:0] wptr_q, wptr_d, wgray_q, wgray_d, rptr_q, rptr_d, rgray_q, rgray_d;
    logic [PW-1:0] rg1_q, rg2_q, wg1_q, wg2_q;
    logic [PW-1:0] wcnt, rcnt;
    logic ovr_q, ovr_d, und_q, und_d;
    logic [NS-1:0][2:0] wpipe_q, wpipe_d, rpipe_q, rpipe_d;
    logic [2:0] wcode, rcode;
    logic wr_req, rd_req, wfull, rempty, wr_ok, rd_ok;

    // Each side sees the far pointer only after two flops
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        rg1_q <= '0;
        rg2_q <= '0;
        wg1_q <= '0;
        wg2_q <= '0;
      end else begin
        rg1_q <= rgray_q;
        rg2_q <= rg1_q;
        wg1_q <= wgray_q;
        wg2_q <= wg1_q;
      end
    end

    assign wcnt = wptr_q - gray2bin(rg2_q);
    assign rcnt = gray2bin(wg2_q) - rptr_q;
    assign wfull = (wcnt == PW'(DEPTH));
    assign rempty = (rcnt == '0);
    assign wr_req = wr_edge & ~wr_en_n_s & (sel_s == 1'(ch)) & i_fifo_pointer_reset_n;
    assign rd_req = ~i_read_en_n & (sel_s == 1'(ch)) & i_fifo_pointer_reset_n;
    assign wr_ok = wr_req & ~wfull;
    assign rd_ok = rd_req & ~rempty;

    // Occupancy and the overrun/underrun error flags decide the codes; word contents are never inspected
    always_comb begin
      if (ovr_q) wcode = adf_pkg::ADF_OVERRUN;
      else if (wfull) wcode = adf_pkg::ADF_FULL;
      else if (wcnt >= PW'(`ADF_ALMOST_FULL)) wcode = adf_pkg::ADF_ALMOST_FULL;
      else if (wcnt >= PW'(`ADF_HALF_FULL)) wcode = adf_pkg::ADF_HALF_FULL;
      else wcode = adf_pkg::ADF_READY;
      if (und_q) rcode = adf_pkg::ADF_UNDERRUN;
      else if (rempty) rcode = adf_pkg::ADF_EMPTY;
      else if (rcnt <= PW'(`ADF_ALMOST_EMPTY)) rcode = adf_pkg::ADF_ALMOST_EMPTY;
      else rcode = adf_pkg::ADF_READY;
    end

    // Pointer, error flag and status pipeline next state
    always_comb begin
      wptr_d = wptr_q;
      wgray_d = wgray_q;
      rptr_d = rptr_q;
      rgray_d = rgray_q;
      ovr_d = ovr_q;
      und_d = und_q;
      wpipe_d = wpipe_q;
      rpipe_d = {rpipe_q[NS-2:0], rcode};
      if (wr_edge) begin
        wpipe_d = {wpipe_q[NS-2:0], wcode};
      end
      if (wr_ok) begin
        wptr_d = wptr_q + 1'b1;
        wgray_d = wptr_d ^ (wptr_d >> 1);
      end
      if (rd_ok) begin
        rptr_d = rptr_q + 1'b1;
        rgray_d = rptr_d ^ (rptr_d >> 1);
      end
      // Error holds until the fill level moves off its limit
      if (wr_req && wfull) ovr_d = 1'b1;
      else if (!wfull) ovr_d = 1'b0;
      if (rd_req && rempty) und_d = 1'b1;
      else if (!rempty) und_d = 1'b0;
      if (!i_fifo_pointer_reset_n) begin
        wptr_d = '0;
        wgray_d = '0;
        rptr_d = '0;
        rgray_d = '0;
        ovr_d = 1'b0;
        und_d = 1'b0;
      end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        wptr_q <= '0;
        wgray_q <= '0;
        rptr_q <= '0;
        rgray_q <= '0;
        ovr_q <= 1'b0;
        und_q <= 1'b0;
        wpipe_q <= {NS{adf_pkg::ADF_READY}};
        rpipe_q <= {NS{adf_pkg::ADF_EMPTY}};
      end else begin
        wptr_q <= wptr_d;
        wgray_q <= wgray_d;
        rptr_q <= rptr_d;
        rgray_q <= rgray_d;
        ovr_q <= ovr_d;
        und_q <= und_d;
        wpipe_q <= wpipe_d;
        rpipe_q <= rpipe_d;
      end
    end

    // Storage has no reset; only pointers define what is valid
    always_ff @(posedge i_core_clk) begin
      if (wr_ok) begin
        mem[wptr_q[AW-1:0]] <= word_s;
      end
    end

    // Low codes come from the read side, high codes from the write side
    assign fifo_code[ch] = (rpipe_q[NS-1] != adf_pkg::ADF_READY) ? rpipe_q[NS-1]
                           : wpipe_q[NS-1];
    assign rd_word[ch] = mem[rptr_q[AW-1:0]];
    assign ins_w[ch] = rd_ok;
    assign ovr_evt[ch] = wr_req & wfull;
    assign und_evt[ch] = rd_req & rempty;
    assign fill_cnt[ch] = rcnt;
  end

  // ----------------------------------------
  // Video path and status pins
  // ----------------------------------------
  logic [DW-1:0] luma_q, luma_d, chroma_q, chroma_d;
  logic [2:0] code_q, code_d;
  logic code_oe_q, code_oe_d;

  // Blanking overrides insertion on both channels in the same cycle
  always_comb begin
    luma_d = ins_w[1] ? rd_word[1] : i_luma_in;
    chroma_d = ins_w[0] ? rd_word[0] : i_chroma_in;
    if (i_blank_req) begin
      luma_d = `ADF_LUMA_BLANK;
      chroma_d = `ADF_CHROMA_BLANK;
    end
    code_d = sel_s ? fifo_code[1] : fifo_code[0];
    code_oe_d = ~stat_en_n_s;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      luma_q <= '0;
      chroma_q <= '0;
      code_q <= adf_pkg::ADF_EMPTY;
      code_oe_q <= 1'b0;
    end else begin
      luma_q <= luma_d;
      chroma_q <= chroma_d;
      code_q <= code_d;
      code_oe_q <= code_oe_d;
    end
  end
  assign o_luma_out = luma_q;
  assign o_chroma_out = chroma_q;
  assign o_fifo_level_code = code_q;
  assign o_fifo_level_code_oe = code_oe_q;

  // ----------------------------------------
  // AXI4-Lite slave and interrupt registers
  // ----------------------------------------
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [AXI_AW-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic wstrb0_q, wstrb0_d;
  logic awrdy_q, awrdy_d, wrdy_q, wrdy_d, bvalid_q, bvalid_d, arrdy_q, arrdy_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [IW-1:0] irq_st_q, irq_st_d, irq_en_q, irq_en_d, irq_clr;
  logic irq_q, irq_d;

  // Write commits once address and data are both held; set beats clear
  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arrdy_d = arrdy_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    irq_en_d = irq_en_q;
    irq_clr = '0;
    if (i_awvalid && awrdy_q) begin
      aw_hold_d = 1'b1;
      awaddr_d = i_awaddr;
    end
    if (i_wvalid && wrdy_q) begin
      w_hold_d = 1'b1;
      wdata_d = i_wdata;
      wstrb0_d = i_wstrb[0];
    end
    if (bvalid_q && i_bready) bvalid_d = 1'b0;
    if (aw_hold_q && w_hold_q && !bvalid_q) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `ADF_RESP_OKAY;
      unique case (awaddr_q)
        AXI_AW'(`ADF_OFF_IRQ_CLEAR): if (wstrb0_q) irq_clr = wdata_q[IW-1:0];
        AXI_AW'(`ADF_OFF_IRQ_ENABLE): if (wstrb0_q) irq_en_d = wdata_q[IW-1:0];
        AXI_AW'(`ADF_OFF_IRQ_STATUS), AXI_AW'(`ADF_OFF_FILL): ;
        default: bresp_d = `ADF_RESP_SLVERR;
      endcase
    end
    awrdy_d = !aw_hold_d && !bvalid_d;
    wrdy_d = !w_hold_d && !bvalid_d;
    if (rvalid_q && i_rready) begin
      rvalid_d = 1'b0;
      arrdy_d = 1'b1;
    end
    if (i_arvalid && arrdy_q) begin
      arrdy_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = `ADF_RESP_OKAY;
      rdata_d = '0;
      unique case (i_araddr)
        AXI_AW'(`ADF_OFF_IRQ_STATUS): rdata_d[IW-1:0] = irq_st_q;
        AXI_AW'(`ADF_OFF_IRQ_ENABLE): rdata_d[IW-1:0] = irq_en_q;
        AXI_AW'(`ADF_OFF_IRQ_CLEAR): ;
        AXI_AW'(`ADF_OFF_FILL): begin
          rdata_d[PW-1:0] = fill_cnt[0];
          rdata_d[16+PW-1:16] = fill_cnt[1];
        end
        default: rresp_d = `ADF_RESP_SLVERR;
      endcase
    end
    irq_st_d = (irq_st_q & ~irq_clr) | {und_evt[1], ovr_evt[1], und_evt[0], ovr_evt[0]};
    irq_d = |(irq_st_q & irq_en_q);
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
      awrdy_q <= 1'b1;
      wrdy_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `ADF_RESP_OKAY;
      arrdy_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `ADF_RESP_OKAY;
      irq_st_q <= '0;
      irq_en_q <= `ADF_IRQ_ENABLE_RST;
      irq_q <= 1'b0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb0_q <= wstrb0_d;
      awrdy_q <= awrdy_d;
      wrdy_q <= wrdy_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arrdy_q <= arrdy_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      irq_st_q <= irq_st_d;
      irq_en_q <= irq_en_d;
      irq_q <= irq_d;
    end
  end
  assign o_awready = awrdy_q;
  assign o_wready = wrdy_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_arready = arrdy_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;
  assign o_irq = irq_q;
endmodule // adf_dual_fifo_status

// file: rtl/adf_pkg.sv
// Purpose: Types shared by the dual ancillary-data FIFO block
// Assumes: Used by scoped names only
// Notes: Status code values are fixed by the output encoding
package adf_pkg;
  // ----------------------------------------
  // Fill-level status codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    ADF_UNDERRUN = 3'h0,
    ADF_EMPTY = 3'h1,
    ADF_ALMOST_EMPTY = 3'h2,
    ADF_READY = 3'h3,
    ADF_HALF_FULL = 3'h4,
    ADF_ALMOST_FULL = 3'h5,
    ADF_FULL = 3'h6,
    ADF_OVERRUN = 3'h7
  } adf_code_type;
endpackage

// file: testbench/adf_dual_fifo_status_props.sv
// Purpose: Port-level checks of the dual ancillary FIFO block
// Assumes: One pixel clock domain
// Notes: Attached by the bind at the foot of this file
`timescale 1ns/1ps
`include "adf_cfg.svh"
module adf_dual_fifo_status_props #(
  parameter int DW = 10
) (
  input wire logic i_core_clk, // Clock
  input wire logic i_arst_n, // Reset
  input wire logic [DW-1:0] i_luma_in, // Luma in
  input wire logic [DW-1:0] i_chroma_in, // Chroma in
  input wire logic i_blank_req, // Blank request
  input wire logic [DW-1:0] o_luma_out, // Luma out
  input wire logic [DW-1:0] o_chroma_out, // Chroma out
  input wire logic i_read_en_n, // Read enable
  input wire logic i_status_flags_enable_n, // Status enable
  input wire logic [2:0] o_fifo_level_code, // Status code
  input wire logic o_fifo_level_code_oe, // Code driven
  input wire logic o_irq, // Interrupt
  input wire logic i_awvalid, // AW valid
  input wire logic o_awready, // AW ready
  input wire logic i_wvalid, // W valid
  input wire logic o_wready, // W ready
  input wire logic o_bvalid, // B valid
  input wire logic i_arvalid, // AR valid
  input wire logic o_arready, // AR ready
  input wire logic o_rvalid // R valid
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);
  // ----------------------------------------
  // Video path and status pins
  // ----------------------------------------
  a_video_pass: assert property (!i_blank_req && i_read_en_n |=>
    o_luma_out == $past(i_luma_in) && o_chroma_out == $past(i_chroma_in))
    else $error("video word not passed through");
  a_blank_both: assert property (i_blank_req |=>
    o_luma_out == `ADF_LUMA_BLANK && o_chroma_out == `ADF_CHROMA_BLANK)
    else $error("channels not blanked together");
  // Two sync flops plus the output register
  a_oe_on: assert property (!i_status_flags_enable_n [*4] |-> o_fifo_level_code_oe)
    else $error("status pins not driven");
  a_oe_off: assert property (i_status_flags_enable_n [*4] |-> !o_fifo_level_code_oe)
    else $error("status pins still driven");
  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready
    |-> ##[1:3] o_bvalid) else $error("write response late");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read data late");
  a_write_busy: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write accepted while response pending");
  a_read_busy: assert property (o_rvalid |-> !o_arready)
    else $error("read accepted while data pending");
  c_underrun: cover property (o_fifo_level_code == 3'h0);
  c_overrun: cover property (o_fifo_level_code == 3'h7);
  c_irq: cover property (o_irq);
endmodule // adf_dual_fifo_status_props

bind adf_dual_fifo_status adf_dual_fifo_status_props #(.DW(DW)) i_adf_dual_fifo_status_props (
  .i_core_clk, .i_arst_n, .i_luma_in, .i_chroma_in, .i_blank_req, .o_luma_out,
  .o_chroma_out, .i_read_en_n, .i_status_flags_enable_n, .o_fifo_level_code,
  .o_fifo_level_code_oe, .o_irq, .i_awvalid, .o_awready, .i_wvalid, .o_wready,
  .o_bvalid, .i_arvalid, .o_arready, .o_rvalid
);

// file: testbench/adf_dual_fifo_status_test.sv
// Purpose: Self-checking bench for the dual ancillary FIFO block
// Assumes: Writer model owns the write clock pins
// Notes: Reads never overlap writes, so every status code read is trustworthy
`timescale 1ns/1ps
`include "adf_cfg.svh"
module adf_dual_fifo_status_test;
  logic core_clk, arst_n, blank_req, sel, read_en_n, ptr_rst_n, sts_en_n;
  logic [9:0] luma_in, chroma_in, luma_out, chroma_out, anc_word;
  logic wr_clk, wr_en_n, oe, irq, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [2:0] code;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int failures = 0;
  int cmp_count = 0;
  adf_writer_model i_adf_writer_model (.o_wr_clk(wr_clk), .o_wr_en_n(wr_en_n),
    .o_word(anc_word));
  adf_dual_fifo_status i_adf_dual_fifo_status (.i_core_clk(core_clk), .i_arst_n(arst_n),
    .i_luma_in(luma_in), .i_chroma_in(chroma_in), .i_blank_req(blank_req),
    .o_luma_out(luma_out), .o_chroma_out(chroma_out), .i_wr_clk(wr_clk),
    .i_wr_en_n(wr_en_n), .i_anc_word_in(anc_word), .i_luma_chroma_select(sel),
    .i_read_en_n(read_en_n), .i_fifo_pointer_reset_n(ptr_rst_n),
    .i_status_flags_enable_n(sts_en_n), .o_fifo_level_code(code),
    .o_fifo_level_code_oe(oe), .o_irq(irq), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));
  // ----------------------------------------
  // Clock, report and compare
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (exp !== got) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Bounded wait for a status code; running out ends the run
  task automatic wait_code(input adf_pkg::adf_code_type exp);
    int n = 0;
    while (code !== exp && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    cmp("status code", 32'(exp), 32'(code));
    if (code !== exp) conclude();
  endtask
  // ----------------------------------------
  // Register bus master
  // ----------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    cmp("write response", 32'(er), 32'(bresp));
    cmp("write answer", 1, 32'(bvalid));
    if (!bvalid) conclude();
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n = 0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    cmp("read data", ed, rdata);
    cmp("read response", 32'(er), 32'(rresp));
    cmp("read answer", 1, 32'(rvalid));
    if (!rvalid) conclude();
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    cmp("reset code", 32'(adf_pkg::ADF_EMPTY), 32'(code));
    axi_rd(`ADF_OFF_IRQ_ENABLE, 32'h0, `ADF_RESP_OKAY);
    axi_rd(8'h40, 32'h0, `ADF_RESP_SLVERR);
    axi_wr(8'h40, 32'h0000_000F, `ADF_RESP_SLVERR);
    axi_wr(`ADF_OFF_FILL, 32'h0000_000F, `ADF_RESP_OKAY);
    axi_rd(`ADF_OFF_FILL, 32'h0, `ADF_RESP_OKAY);
    axi_rd(`ADF_OFF_IRQ_CLEAR, 32'h0, `ADF_RESP_OKAY);
    sts_en_n <= 1'b1;
    cyc(5);
    cmp("oe off", 0, 32'(oe));
    sts_en_n <= 1'b0;
    cyc(5);
    cmp("oe on", 1, 32'(oe));
    $display("test reset done");
  endtask
  task automatic t_video();
    @(posedge core_clk);
    luma_in <= 10'h155;
    chroma_in <= 10'h2AA;
    @(posedge core_clk);
    blank_req <= 1'b1;
    #1 cmp("luma out", 32'h155, 32'(luma_out));
    cmp("chroma out", 32'h2AA, 32'(chroma_out));
    @(posedge core_clk);
    blank_req <= 1'b0;
    #1 cmp("luma blank", `ADF_LUMA_BLANK, 32'(luma_out));
    cmp("chroma blank", `ADF_CHROMA_BLANK, 32'(chroma_out));
    $display("test video done");
  endtask
  // Interrupt enable, then chroma read while empty, then interrupt clear
  task automatic t_underrun();
    axi_wr(`ADF_OFF_IRQ_ENABLE, 32'h0000_000F, `ADF_RESP_OKAY);
    @(posedge core_clk);
    read_en_n <= 1'b0;
    @(posedge core_clk);
    read_en_n <= 1'b1;
    #1 cmp("chroma untouched", 32'h2AA, 32'(chroma_out));
    wait_code(adf_pkg::ADF_UNDERRUN);
    axi_rd(`ADF_OFF_IRQ_STATUS, 32'h2, `ADF_RESP_OKAY);
    cmp("irq raised", 1, 32'(irq));
    axi_wr(`ADF_OFF_IRQ_CLEAR, 32'h2, `ADF_RESP_OKAY);
    axi_rd(`ADF_OFF_IRQ_STATUS, 32'h0, `ADF_RESP_OKAY);
    cmp("irq cleared", 0, 32'(irq));
    cmp("error sticky", 32'(adf_pkg::ADF_UNDERRUN), 32'(code));
    $display("test underrun done");
  endtask
  // Three luma words in, then read back; writes finish before reads start
  task automatic t_write_read();
    @(posedge core_clk);
    sel <= 1'b1;
    cyc(4);
    cmp("luma code", 32'(adf_pkg::ADF_EMPTY), 32'(code));
    i_adf_writer_model.send(3, 10'h101);
    wait_code(adf_pkg::ADF_ALMOST_EMPTY);
    axi_rd(`ADF_OFF_FILL, 32'h0003_0000, `ADF_RESP_OKAY);
    @(posedge core_clk);
    read_en_n <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      if (i == 2) read_en_n <= 1'b1;
      #1 cmp("inserted word", 32'(10'h101 + i), 32'(luma_out));
    end
    cyc(5);
    cmp("emptied code", 32'(adf_pkg::ADF_EMPTY), 32'(code));
    sel <= 1'b0;
    cyc(4);
    cmp("chroma code", 32'(adf_pkg::ADF_UNDERRUN), 32'(code));
    sel <= 1'b1;
    $display("test write read done");
  endtask
  // Luma filled through every write-side threshold, then one write too many
  task automatic t_fill();
    i_adf_writer_model.send(512, 10'h000);
    wait_code(adf_pkg::ADF_HALF_FULL);
    i_adf_writer_model.send(480, 10'h000);
    wait_code(adf_pkg::ADF_ALMOST_FULL);
    i_adf_writer_model.send(32, 10'h000);
    wait_code(adf_pkg::ADF_FULL);
    i_adf_writer_model.send(1, 10'h000);
    wait_code(adf_pkg::ADF_OVERRUN);
    axi_rd(`ADF_OFF_IRQ_STATUS, 32'h4, `ADF_RESP_OKAY);
    axi_rd(`ADF_OFF_FILL, 32'h0400_0000, `ADF_RESP_OKAY);
    ptr_rst_n <= 1'b0;
    @(posedge core_clk);
    ptr_rst_n <= 1'b1;
    wait_code(adf_pkg::ADF_EMPTY);
    $display("test fill done");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    arst_n = 1'b0;
    blank_req = 1'b0;
    sel = 1'b0;
    read_en_n = 1'b1;
    ptr_rst_n = 1'b1;
    sts_en_n = 1'b0;
    luma_in = 10'h000;
    chroma_in = 10'h000;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset();
    t_video();
    t_underrun();
    t_write_read();
    t_fill();
    conclude();
  end
endmodule // adf_dual_fifo_status_test

// file: testbench/adf_writer_model.sv
// Purpose: User logic that loads ancillary words on its own clock
// Assumes: Caller keeps the select input steady during a burst
// Notes: Clock runs only inside a burst, with four idle clocks at its end
`timescale 1ns/1ps
module adf_writer_model (
  output logic o_wr_clk, // Writer clock
  output logic o_wr_en_n, // Write enable, active low
  output logic [9:0] o_word // Ancillary word
);
  // Idle: enable released high, data inverted so a stale word is never reused
  initial begin
    o_wr_clk = 1'b0;
    o_wr_en_n = 1'b1;
    o_word = 10'h3FF;
  end
  // One word per 800 ns clock; bursts are sized by the caller, and the last t_fill burst overfills the FIFO
  task automatic send(input int n, input logic [9:0] base);
    // Quarter core period offset keeps every pin change off a core sampling edge
    #25;
    for (int i = 0; i < n + 4; i++) begin
      o_wr_en_n = (i >= n);
      o_word = base + 10'(i);
      #230 o_wr_clk = 1'b1;
      #400 o_wr_clk = 1'b0;
      #170;
    end
    o_wr_en_n = 1'b1;
    o_word = ~o_word;
    // Time passes before return, so a following burst never reassigns pins now
    #25;
  endtask
endmodule // adf_writer_model
